// ---- ifsb_regs.svh ----
// register map, field positions and reset values of the interrupt flag bank
`ifndef IFSB_REGS_SVH
`define IFSB_REGS_SVH

`define IFSB_ADDR_FLAGS0 4'h0
`define IFSB_ADDR_FLAGS1 4'h1
`define IFSB_ADDR_FLAGS2 4'h2
`define IFSB_RESET_FLAGS 16'h0000
`define IFSB_MASK0 16'h7FFF
`define IFSB_MASK1 16'hFF5F
`define IFSB_MASK2 16'h6FF3

`define IFSB_F0_DMA1 14
`define IFSB_F0_ADC 13
`define IFSB_F0_UA_TX 12
`define IFSB_F0_UA_RX 11
`define IFSB_F0_SPA_EV 10
`define IFSB_F0_SPA_FLT 9
`define IFSB_F0_TMR_C 8
`define IFSB_F0_TMR_B 7
`define IFSB_F0_OC_B 6
`define IFSB_F0_IC_B 5
`define IFSB_F0_DMA0 4
`define IFSB_F0_TMR_A 3
`define IFSB_F0_OC_A 2
`define IFSB_F0_IC_A 1
`define IFSB_F0_EXT_A 0

`define IFSB_F1_UB_TX 15
`define IFSB_F1_UB_RX 14
`define IFSB_F1_EXT_C 13
`define IFSB_F1_TMR_E 12
`define IFSB_F1_TMR_D 11
`define IFSB_F1_OC_D 10
`define IFSB_F1_OC_C 9
`define IFSB_F1_DMA2 8
`define IFSB_F1_IC_G 6
`define IFSB_F1_EXT_B 4
`define IFSB_F1_PIN_CHG 3
`define IFSB_F1_CMP 2
`define IFSB_F1_I2C_M 1
`define IFSB_F1_I2C_S 0

`define IFSB_F2_DMA4 14
`define IFSB_F2_PAR 13
`define IFSB_F2_OC_G 11
`define IFSB_F2_OC_F 10
`define IFSB_F2_OC_E 9
`define IFSB_F2_IC_F 8
`define IFSB_F2_IC_E 7
`define IFSB_F2_IC_D 6
`define IFSB_F2_IC_C 5
`define IFSB_F2_DMA3 4
`define IFSB_F2_SPB_EV 1
`define IFSB_F2_SPB_FLT 0

`endif

// ---- ifsb_pkg.sv ----
// types shared by the interrupt flag bank modules
package ifsb_pkg;
  typedef logic [15:0] ifsb_word_t;
  typedef logic [3:0] ifsb_addr_t;
  typedef enum logic [1:0] {IFSB_SEL_F0, IFSB_SEL_F1, IFSB_SEL_F2, IFSB_SEL_NONE} ifsb_sel_t;
endpackage

// ---- ifsb_flag_if.sv ----
// link between the bank control and one flag register
`timescale 1ns/1ps
`default_nettype none
interface ifsb_flag_if;
  import ifsb_pkg::*;
  logic wr;
  ifsb_word_t wdata;
  ifsb_word_t set;
  ifsb_word_t value;
  modport bank (input wr, input wdata, input set, output value);
  modport ctl (output wr, output wdata, output set, input value);
endinterface
`default_nettype wire

// ---- ifsb_flag_bank.sv ----
// one sticky 16-bit flag register with an implemented-bit mask
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_regs.svh"
module ifsb_flag_bank #(
  parameter ifsb_pkg::ifsb_word_t MASK = 16'hFFFF
) (
  input wire logic clock,
  input wire logic nrst,
  ifsb_flag_if.bank bus
);
  import ifsb_pkg::*;

  ifsb_word_t flags_q;
  ifsb_word_t flags_d;

  always_comb
  begin
    // request or a written 1 sets; set beats a same-cycle clear
    flags_d = ((bus.wr ? bus.wdata : flags_q) | bus.set) & MASK;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      flags_q <= `IFSB_RESET_FLAGS;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign bus.value = flags_q;
endmodule
`default_nettype wire

// ---- ifsb_flag_status.sv ----
// three interrupt flag registers with source set inputs and register port
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_regs.svh"
module ifsb_flag_status (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic dma_channel1_req,
  input wire logic adc_done_req,
  input wire logic uart_a_transmit_req,
  input wire logic uart_a_receive_req,
  input wire logic serial_periph_a_event_req,
  input wire logic serial_periph_a_fault_req,
  input wire logic timer_c_req,
  input wire logic timer_b_req,
  input wire logic out_compare_b_req,
  input wire logic in_capture_b_req,
  input wire logic dma_channel0_req,
  input wire logic timer_a_req,
  input wire logic out_compare_a_req,
  input wire logic in_capture_a_req,
  input wire logic ext_irq_a_req,
  input wire logic uart_b_transmit_req,
  input wire logic uart_b_receive_req,
  input wire logic ext_irq_c_req,
  input wire logic timer_e_req,
  input wire logic timer_d_req,
  input wire logic out_compare_d_req,
  input wire logic out_compare_c_req,
  input wire logic dma_channel2_req,
  input wire logic in_capture_g_req,
  input wire logic ext_irq_b_req,
  input wire logic pin_change_req,
  input wire logic comparator_req,
  input wire logic i2c_a_master_req,
  input wire logic i2c_a_slave_req,
  input wire logic dma_channel4_req,
  input wire logic parallel_port_req,
  input wire logic out_compare_g_req,
  input wire logic out_compare_f_req,
  input wire logic out_compare_e_req,
  input wire logic in_capture_f_req,
  input wire logic in_capture_e_req,
  input wire logic in_capture_d_req,
  input wire logic in_capture_c_req,
  input wire logic dma_channel3_req,
  input wire logic serial_periph_b_event_req,
  input wire logic serial_periph_b_fault_req,
  output logic [15:0] interrupt_flags_0,
  output logic [15:0] interrupt_flags_1,
  output logic [15:0] interrupt_flags_2,
  output logic flags_pending
);
  import ifsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the write and the read path

  function automatic ifsb_sel_t addr_sel(input ifsb_addr_t addr);
    ifsb_sel_t sel;
    sel = IFSB_SEL_NONE;
    unique case (addr)
      `IFSB_ADDR_FLAGS0: sel = IFSB_SEL_F0;
      `IFSB_ADDR_FLAGS1: sel = IFSB_SEL_F1;
      `IFSB_ADDR_FLAGS2: sel = IFSB_SEL_F2;
      default: sel = IFSB_SEL_NONE;
    endcase
    return sel;
  endfunction

  ifsb_flag_if f0 ();
  ifsb_flag_if f1 ();
  ifsb_flag_if f2 ();

  ifsb_sel_t wsel;
  ifsb_sel_t rsel;
  ifsb_word_t rdata_q;
  ifsb_word_t rdata_d;
  logic pending_q;

  assign wsel = addr_sel(reg_addr);
  assign rsel = addr_sel(reg_addr);

  ////////////////////////////////////////////////////////////////////////////
  // source requests placed at their bit positions

  always_comb
  begin
    f0.set = `IFSB_RESET_FLAGS;
    f0.set[`IFSB_F0_DMA1] = dma_channel1_req;
    f0.set[`IFSB_F0_ADC] = adc_done_req;
    f0.set[`IFSB_F0_UA_TX] = uart_a_transmit_req;
    f0.set[`IFSB_F0_UA_RX] = uart_a_receive_req;
    f0.set[`IFSB_F0_SPA_EV] = serial_periph_a_event_req;
    f0.set[`IFSB_F0_SPA_FLT] = serial_periph_a_fault_req;
    f0.set[`IFSB_F0_TMR_C] = timer_c_req;
    f0.set[`IFSB_F0_TMR_B] = timer_b_req;
    f0.set[`IFSB_F0_OC_B] = out_compare_b_req;
    f0.set[`IFSB_F0_IC_B] = in_capture_b_req;
    f0.set[`IFSB_F0_DMA0] = dma_channel0_req;
    f0.set[`IFSB_F0_TMR_A] = timer_a_req;
    f0.set[`IFSB_F0_OC_A] = out_compare_a_req;
    f0.set[`IFSB_F0_IC_A] = in_capture_a_req;
    f0.set[`IFSB_F0_EXT_A] = ext_irq_a_req;
  end

  always_comb
  begin
    f1.set = `IFSB_RESET_FLAGS;
    f1.set[`IFSB_F1_UB_TX] = uart_b_transmit_req;
    f1.set[`IFSB_F1_UB_RX] = uart_b_receive_req;
    f1.set[`IFSB_F1_EXT_C] = ext_irq_c_req;
    f1.set[`IFSB_F1_TMR_E] = timer_e_req;
    f1.set[`IFSB_F1_TMR_D] = timer_d_req;
    f1.set[`IFSB_F1_OC_D] = out_compare_d_req;
    f1.set[`IFSB_F1_OC_C] = out_compare_c_req;
    f1.set[`IFSB_F1_DMA2] = dma_channel2_req;
    f1.set[`IFSB_F1_IC_G] = in_capture_g_req;
    f1.set[`IFSB_F1_EXT_B] = ext_irq_b_req;
    f1.set[`IFSB_F1_PIN_CHG] = pin_change_req;
    f1.set[`IFSB_F1_CMP] = comparator_req;
    f1.set[`IFSB_F1_I2C_M] = i2c_a_master_req;
    f1.set[`IFSB_F1_I2C_S] = i2c_a_slave_req;
  end

  always_comb
  begin
    f2.set = `IFSB_RESET_FLAGS;
    f2.set[`IFSB_F2_DMA4] = dma_channel4_req;
    f2.set[`IFSB_F2_PAR] = parallel_port_req;
    f2.set[`IFSB_F2_OC_G] = out_compare_g_req;
    f2.set[`IFSB_F2_OC_F] = out_compare_f_req;
    f2.set[`IFSB_F2_OC_E] = out_compare_e_req;
    f2.set[`IFSB_F2_IC_F] = in_capture_f_req;
    f2.set[`IFSB_F2_IC_E] = in_capture_e_req;
    f2.set[`IFSB_F2_IC_D] = in_capture_d_req;
    f2.set[`IFSB_F2_IC_C] = in_capture_c_req;
    f2.set[`IFSB_F2_DMA3] = dma_channel3_req;
    f2.set[`IFSB_F2_SPB_EV] = serial_periph_b_event_req;
    f2.set[`IFSB_F2_SPB_FLT] = serial_periph_b_fault_req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write path; writes to unmapped addresses are dropped

  assign f0.wr = reg_write && (wsel == IFSB_SEL_F0);
  assign f1.wr = reg_write && (wsel == IFSB_SEL_F1);
  assign f2.wr = reg_write && (wsel == IFSB_SEL_F2);
  assign f0.wdata = reg_wdata;
  assign f1.wdata = reg_wdata;
  assign f2.wdata = reg_wdata;

  // masks keep unimplemented positions at 0 whatever is written or requested
  ifsb_flag_bank #(
    .MASK(`IFSB_MASK0)
  ) u_bank0 (
    .clock(clock),
    .nrst(nrst),
    .bus(f0)
  );

  ifsb_flag_bank #(
    .MASK(`IFSB_MASK1)
  ) u_bank1 (
    .clock(clock),
    .nrst(nrst),
    .bus(f1)
  );

  ifsb_flag_bank #(
    .MASK(`IFSB_MASK2)
  ) u_bank2 (
    .clock(clock),
    .nrst(nrst),
    .bus(f2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path: data valid only in the cycle after the strobe

  always_comb
  begin
    rdata_d = `IFSB_RESET_FLAGS;
    if (reg_read)
    begin
      unique case (rsel)
        IFSB_SEL_F0: rdata_d = f0.value;
        IFSB_SEL_F1: rdata_d = f1.value;
        IFSB_SEL_F2: rdata_d = f2.value;
        IFSB_SEL_NONE: rdata_d = `IFSB_RESET_FLAGS;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rdata_q <= `IFSB_RESET_FLAGS;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summary for the priority logic; lags the flags by one cycle

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pending_q <= 1'b0;
    end
    else
    begin
      pending_q <= |{f0.value, f1.value, f2.value};
    end
  end

  assign reg_rdata = rdata_q;
  assign interrupt_flags_0 = f0.value;
  assign interrupt_flags_1 = f1.value;
  assign interrupt_flags_2 = f2.value;
  assign flags_pending = pending_q;
endmodule
`default_nettype wire

// ---- ifsb_flag_status_sva.sv ----
// concurrent checks on the flag bank ports
`timescale 1ns/1ps
`default_nettype none
module ifsb_flag_status_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic timer_a_req,
  input wire logic serial_periph_b_fault_req,
  input wire logic [15:0] interrupt_flags_0,
  input wire logic [15:0] interrupt_flags_1,
  input wire logic [15:0] interrupt_flags_2,
  input wire logic flags_pending
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence rd0_s;
    reg_read && reg_addr == 4'h0;
  endsequence
  sequence ta_s;
    timer_a_req ##1 interrupt_flags_0[3];
  endsequence
  unimpl0_zero_a: assert property (interrupt_flags_0[15] == 1'b0) else $error("flags0 bit 15 set");
  unimpl1_zero_a: assert property ((interrupt_flags_1 & 16'h00A0) == 16'h0000) else $error("flags1 gap set");
  unimpl2_zero_a: assert property ((interrupt_flags_2 & 16'h900C) == 16'h0000) else $error("flags2 gap set");
  reset_clear_a: assert property (disable iff (1'b0) !nrst |=>
    {interrupt_flags_0, interrupt_flags_1, interrupt_flags_2, reg_rdata} == 64'h0) else $error("reset left data");
  timer_set_a: assert property (timer_a_req |=> interrupt_flags_0[3]) else $error("timer a flag not set");
  fault_set_a: assert property (serial_periph_b_fault_req |=> interrupt_flags_2[0]) else $error("fault flag");
  flag_hold_a: assert property (interrupt_flags_0[3] && !(reg_write && reg_addr == 4'h0) |=>
    interrupt_flags_0[3]) else $error("flag dropped");
  write_set_a: assert property (reg_write && reg_addr == 4'h0 |=>
    (interrupt_flags_0 | ~($past(reg_wdata) & 16'h7FFF)) == 16'hFFFF) else $error("written one lost");
  read_back_a: assert property (rd0_s |=> reg_rdata == $past(interrupt_flags_0)) else $error("read data");
  rdata_quiet_a: assert property (!reg_read || reg_addr > 4'h2 |=> reg_rdata == 16'h0000) else $error("rdata");
  pending_a: assert property (ta_s |=> flags_pending) else $error("pending missing");
endmodule
////////////////////////////////////////////////////////////////
bind ifsb_flag_status ifsb_flag_status_sva u_sva (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .timer_a_req(timer_a_req), .serial_periph_b_fault_req(serial_periph_b_fault_req),
  .interrupt_flags_0(interrupt_flags_0), .interrupt_flags_1(interrupt_flags_1),
  .interrupt_flags_2(interrupt_flags_2), .flags_pending(flags_pending));
`default_nettype wire

// ---- ifsb_src_model.sv ----
// peripheral request sources: one-cycle pulse on the commanded lines
`timescale 1ns/1ps
`default_nettype none
module ifsb_src_model (
  input wire logic clock,
  input wire logic go,
  input wire logic [47:0] pat,
  output logic [47:0] req
);
  // sources release their lines at once, so stickiness is the bank's job
  always_ff @(posedge clock)
  begin
    req <= go ? pat : 48'h0;
  end
endmodule
`default_nettype wire

// ---- ifsb_flag_status_tb.sv ----
// self-checking bench for the interrupt flag bank
`timescale 1ns/1ps
`default_nettype none
`include "ifsb_regs.svh"
module ifsb_flag_status_tb;
  logic clock, nrst, reg_write, reg_read, go;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [47:0] pat;
  wire [47:0] q;
  wire [15:0] reg_rdata, f0, f1, f2;
  wire pend;
  wire [47:0] fl = {f2, f1, f0};
  wire [47:0] m = {`IFSB_MASK2, `IFSB_MASK1, `IFSB_MASK0};
  int errors = 0;
  int checked = 0;
  ifsb_src_model u_ifsb_src_model (.clock(clock), .go(go), .pat(pat), .req(q));
  // q[16*w+b] drives bit b of flag word w
  ifsb_flag_status u_ifsb_flag_status (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .dma_channel1_req(q[14]),
    .adc_done_req(q[13]), .uart_a_transmit_req(q[12]), .uart_a_receive_req(q[11]),
    .serial_periph_a_event_req(q[10]), .serial_periph_a_fault_req(q[9]), .timer_c_req(q[8]),
    .timer_b_req(q[7]), .out_compare_b_req(q[6]), .in_capture_b_req(q[5]), .dma_channel0_req(q[4]),
    .timer_a_req(q[3]), .out_compare_a_req(q[2]), .in_capture_a_req(q[1]), .ext_irq_a_req(q[0]),
    .uart_b_transmit_req(q[31]), .uart_b_receive_req(q[30]), .ext_irq_c_req(q[29]), .timer_e_req(q[28]),
    .timer_d_req(q[27]), .out_compare_d_req(q[26]), .out_compare_c_req(q[25]), .dma_channel2_req(q[24]),
    .in_capture_g_req(q[22]), .ext_irq_b_req(q[20]), .pin_change_req(q[19]), .comparator_req(q[18]),
    .i2c_a_master_req(q[17]), .i2c_a_slave_req(q[16]), .dma_channel4_req(q[46]), .parallel_port_req(q[45]),
    .out_compare_g_req(q[43]), .out_compare_f_req(q[42]), .out_compare_e_req(q[41]),
    .in_capture_f_req(q[40]), .in_capture_e_req(q[39]), .in_capture_d_req(q[38]),
    .in_capture_c_req(q[37]), .dma_channel3_req(q[36]), .serial_periph_b_event_req(q[33]),
    .serial_periph_b_fault_req(q[32]), .interrupt_flags_0(f0), .interrupt_flags_1(f1),
    .interrupt_flags_2(f2), .flags_pending(pend));
  ////////////////////////////////////////////////////////////////
  task chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk({32'h0, reg_rdata}, {32'h0, exp});
  endtask
  task end_of_test;
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // every source line on its own, so a swapped pair shows up
  task t_sources;
    for (int i = 0; i < 48; i++)
      if (m[i])
      begin
        @(posedge clock);
        go <= 1'b1;
        pat <= 48'h1 << i;
        @(posedge clock);
        go <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk(fl, 48'h1 << i);
        chk({47'h0, pend}, 48'h1);
        wr(4'(i / 16), 16'h0000);
        #1 chk(fl, 48'h0);
      end
  endtask
  task t_regs;
    for (int a = 0; a < 4; a++)
      wr(4'(a), 16'hFFFF);
    wr(4'hF, 16'hFFFF);
    rd(4'h0, `IFSB_MASK0);
    rd(4'h1, `IFSB_MASK1);
    rd(4'h2, `IFSB_MASK2);
    rd(4'h3, 16'h0000);
    rd(4'hF, 16'h0000);
    for (int a = 0; a < 3; a++)
    begin
      wr(4'(a), 16'h0000);
      rd(4'(a), 16'h0000);
    end
  endtask
  // request and clearing write meet at one edge: the request must win
  task t_race;
    @(posedge clock);
    go <= 1'b1;
    pat <= 48'h8;
    @(posedge clock);
    go <= 1'b0;
    reg_addr <= 4'h0;
    reg_wdata <= 16'h0000;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1 chk(fl, 48'h8);
    wr(4'h0, 16'h0000);
    #1 chk(fl, 48'h0);
  endtask
  task t_reset;
    wr(4'h1, 16'hFFFF);
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    #1 chk(fl, 48'h0);
    chk({47'h0, pend}, 48'h0);
    rd(4'h1, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    // whole run is well under a thousand cycles
    #2000000;
    errors++;
    end_of_test();
  end
  initial
  begin
    nrst = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    go = 1'b0;
    pat = 48'h0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    #1 chk(fl, 48'h0);
    chk({47'h0, pend}, 48'h0);
    rd(4'h0, 16'h0000);
    t_sources();
    t_regs();
    t_race();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
